//--- pkg/ata_pkg.sv
// Purpose: Shared constants for the task-file status/control block
// Assumes: 100 MHz mclk on both ends
// Notes:   Task-file offsets are 4-bit register indices
package ata_pkg;
  // Task-file register indices
  localparam logic [3:0] TF_ERROR   = 4'h1;
  localparam logic [3:0] TF_SECCNT  = 4'h2;
  localparam logic [3:0] TF_SECNUM  = 4'h3;
  localparam logic [3:0] TF_CYLLO   = 4'h4;
  localparam logic [3:0] TF_CYLHI   = 4'h5;
  localparam logic [3:0] TF_DRVHEAD = 4'h6;
  localparam logic [3:0] TF_STATUS  = 4'h7;
  localparam logic [3:0] TF_ALTSTAT = 4'hE;
  localparam logic [3:0] TF_DRVADDR = 4'hF;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK  = 4;
  localparam int ST_DRQ   = 3;
  localparam int ST_FIXED = 2;
  localparam int ST_ERR  = 0;
  // Drive control, error and drive/head fields
  localparam int DC_SRST = 2;
  localparam int DC_NIEN = 1;
  localparam logic [7:0] DC_USED_MASK = 8'h06;
  localparam logic [7:0] ERR_ABORT    = 8'h04;
  localparam logic [7:0] ERR_MASK     = 8'hD5;
  localparam logic [7:0] BUSY_ONLY    = 8'h80;
  localparam int DH_DRV = 4;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BSY_SET_NS    = 400;
  localparam int BSY_SET_CYC   = BSY_SET_NS / CLK_PERIOD_NS;
  localparam int DRQ_OUT_US    = 700;
  localparam int DRQ_OUT_CYC   = DRQ_OUT_US * 1000 / CLK_PERIOD_NS;
  localparam int DRQ_IN_MS     = 20;
  localparam int DRQ_IN_CYC    = DRQ_IN_MS * 1000000 / CLK_PERIOD_NS;
  // Host-side Avalon word addresses and ACCESS fields
  localparam logic [1:0] HR_ACCESS = 2'h0;
  localparam logic [1:0] HR_RESULT = 2'h1;
  localparam logic [1:0] HR_LINK   = 2'h2;
  localparam int AC_ADDR_LO = 8;
  localparam int AC_WE      = 12;
  // Command acceptance classes
  typedef enum logic [1:0] {
    CL_BAD    = 2'h0,
    CL_NODATA = 2'h1,
    CL_OUT    = 2'h2,
    CL_IN     = 2'h3
  } ata_class_t;
endpackage : ata_pkg

//--- pkg/ata_if.sv
// Purpose: Task-file link between host adapter and card
// Assumes: Both ends on mclk; host holds req until ack
// Notes:   ack is a one-cycle pulse carrying rdata
`timescale 1ns/1ps
interface ata_if;
  logic       req;
  logic       we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       intrq;
  logic       dmarq;
  modport device (input req, input we, input addr, input wdata,
                  output ack, output rdata, output intrq, output dmarq);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input intrq, input dmarq);
endinterface : ata_if

//--- rtl/ata_device.sv
// Purpose: Card end: status, drive control, drive address, command intake
// Assumes: Back end reports media state and command progress on mclk
// Notes on behaviour
// - Status read clears interrupt; shadow read does not
// - Status flags fixed order; index bit reads 0
// - Busy locks host out of command and registers
// - DMARQ only while busy or data request
// - Ready low until card accepts; seek-complete follows
// - Write fault sets the write-fault flag
// - Corrected data flagged; multi-sector read continues
// - Error flag set; cause kept in error register
// - Failing sector address left in task file
// - Drive control writable at any time
// - Soft reset held until bit cleared
// - Active-low interrupt enable, cleared on reset
// - Drive control bits 7-3 and 0 ignored
// - Write gate low during write operation
// - Drive address returns inverted head bits
// - Drive select bits low when drive active
// - Host loads parameters, then writes command
// - Host issues commands only when not busy
// - Class 1 busy within 400 ns
// - Class 2 data request within 700 us
// - Class 3 data request within 20 ms
// - Listed and unknown opcodes unsupported; classed and 1xh/7xh opcodes executed
// - Invalid or aborted command sets abort bit
// - Low drive/head bits hold head number
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module ata_device #(
  parameter int DRIVE_ID    = 0,
  parameter int DRQ_OUT_LIM = ata_pkg::DRQ_OUT_CYC,
  parameter int DRQ_IN_LIM  = ata_pkg::DRQ_IN_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  ata_if.device            tf,
  input  wire logic        media_ready,
  input  wire logic        write_fault_evt,
  input  wire logic        corrected_evt,
  input  wire logic        buf_ready,
  input  wire logic        op_done,
  input  wire logic        op_error,
  input  wire logic [7:0]  op_err_bits,
  input  wire logic        fail_addr_valid,
  input  wire logic [27:0] fail_addr,
  output logic             cmd_start,
  output logic [7:0]       cmd_opcode,
  output logic             data_phase,
  output logic             soft_reset,
  output logic             config_int,
  output logic [7:0]       task_count,
  output logic [7:0]       task_feature,
  output logic [7:0]       task_drvhead,
  output logic [23:0]      task_addr
);
  import ata_pkg::*;

  if (DRIVE_ID < 0 || DRIVE_ID > 1 || DRQ_OUT_LIM < 1 || DRQ_IN_LIM < 1
      || BSY_SET_CYC < 1) begin : g_bad_cfg
    $error("ata_device: unsupported parameter values");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EXEC = 4'b0010,
    S_PREP = 4'b0100,
    S_XFER = 4'b1000
  } ata_dev_state_t;

  ata_dev_state_t state;
  ata_class_t     cls;
  logic [31:0]    timer;
  logic [7:0]     errreg;
  logic           busy, drq, err, rdy, nien, intr_pend;
  logic           write_fault_flag, corrected_data_flag;
  logic           is_out, is_dma, bad_cmd;
  logic           take, cmd_wr, ctl_wr, stat_rd, time_up;
  logic           end_ok, end_err, drq_set;
  logic           ds1_n, ds0_n;
  logic [7:0]     status;

  ///////////////////////////////////////////////////////////////////////////
  // Opcode classes
  function automatic ata_class_t classify(input logic [7:0] op);
    case (op)
      8'h00, 8'h22, 8'h23, 8'h32, 8'h33, 8'hB9, 8'hE7,
      8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6:
        classify = CL_BAD;
      8'h30, 8'h31, 8'h38, 8'h3C, 8'h50, 8'hC5, 8'hCA, 8'hCD, 8'hE8:
        classify = CL_OUT;
      8'h20, 8'h21, 8'hC4, 8'hC8, 8'hE4, 8'hEC:
        classify = CL_IN;
      8'hE5, 8'h98, 8'h90, 8'hC0, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'h91,
      8'h40, 8'h41, 8'h03, 8'hEF, 8'hC6, 8'hE6, 8'h99, 8'hE2, 8'h96,
      8'hE0, 8'h94, 8'h87:
        classify = CL_NODATA;
      default:
        classify = (op[7:4] == 4'h1 || op[7:4] == 4'h7) ? CL_NODATA : CL_BAD;
    endcase
  endfunction : classify

  assign status = {busy, rdy, write_fault_flag, rdy, drq,
                   corrected_data_flag, 1'b0, err};
  assign take    = tf.req & ~tf.ack;
  assign ctl_wr  = take & tf.we & (tf.addr == TF_ALTSTAT);
  assign stat_rd = take & ~tf.we & (tf.addr == TF_STATUS);
  // Commands while busy are dropped; the host must wait
  assign cmd_wr  = take & tf.we & (tf.addr == TF_STATUS) & ~busy
                   & ~soft_reset & (state == S_IDLE);
  assign time_up = timer >= (is_out ? 32'(DRQ_OUT_LIM - 1)
                                    : 32'(DRQ_IN_LIM - 1));
  assign drq_set = (state == S_PREP) & buf_ready & ~op_error;
  assign end_err = ((state == S_EXEC) & (bad_cmd | op_error))
                 | ((state == S_PREP) & ~buf_ready & (op_error | time_up))
                 | ((state == S_XFER) & op_error);
  assign end_ok  = ~end_err & (((state == S_EXEC) & op_done)
                 | ((state == S_XFER) & op_done));
  // Selected and active only once the card is ready
  assign ds1_n = ~(rdy & tf_drv_is(1));
  assign ds0_n = ~(rdy & tf_drv_is(0));

  function automatic logic tf_drv_is(input int id);
    tf_drv_is = (DRIVE_ID == id) && (task_drvhead[DH_DRV] == id[0]);
  endfunction : tf_drv_is

  ///////////////////////////////////////////////////////////////////////////
  // Drive control: hardware reset only clears it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      soft_reset <= 1'b0;
      nien       <= 1'b0;
    end else if (ctl_wr) begin
      soft_reset <= tf.wdata[DC_SRST];
      nien       <= tf.wdata[DC_NIEN];
    end
  end

  // Ready follows the back end a cycle late, low from the cycle after soft reset rises
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) rdy <= 1'b0;
    else rdy <= media_ready & ~soft_reset;
  end

  ///////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      busy  <= 1'b0;
      drq   <= 1'b0;
      timer <= 32'h0000_0000;
    end else if (soft_reset) begin
      state <= S_IDLE;
      busy  <= 1'b1;
      drq   <= 1'b0;
      timer <= 32'h0000_0000;
    end else begin
      case (state)
        S_IDLE: begin
          busy  <= cmd_wr;
          timer <= 32'h0000_0000;
          if (cmd_wr) begin
            state <= (cls == CL_OUT || cls == CL_IN) ? S_PREP : S_EXEC;
          end
        end
        S_EXEC: begin
          if (end_err | end_ok) begin
            state <= S_IDLE;
            busy  <= 1'b0;
          end
        end
        S_PREP: begin
          timer <= timer + 32'h0000_0001;
          // Data request rises and busy drops on one edge
          if (drq_set) begin
            state <= S_XFER;
            drq   <= 1'b1;
            busy  <= 1'b0;
          end else if (end_err) begin
            state <= S_IDLE;
            busy  <= 1'b0;
          end
        end
        S_XFER: begin
          // Corrected errors do not end the transfer
          if (end_err | end_ok) begin
            state <= S_IDLE;
            drq   <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
          busy  <= 1'b0;
          drq   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      is_out     <= 1'b0;
      is_dma     <= 1'b0;
      bad_cmd    <= 1'b0;
      cmd_start  <= 1'b0;
      cmd_opcode <= 8'h00;
    end else begin
      cmd_start <= cmd_wr & (cls != CL_BAD);
      if (cmd_wr) begin
        is_out     <= (cls == CL_OUT);
        is_dma     <= (tf.wdata == 8'hC8) || (tf.wdata == 8'hCA);
        bad_cmd    <= (cls == CL_BAD);
        cmd_opcode <= tf.wdata;
      end
    end
  end

  assign cls = classify(tf.wdata);

  ///////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      write_fault_flag    <= 1'b0;
      corrected_data_flag <= 1'b0;
      err                 <= 1'b0;
      errreg              <= 8'h00;
    end else if (soft_reset) begin
      write_fault_flag    <= 1'b0;
      corrected_data_flag <= 1'b0;
      err                 <= 1'b0;
      errreg              <= 8'h00;
    end else begin
      if (cmd_wr) begin
        write_fault_flag    <= write_fault_evt;
        corrected_data_flag <= corrected_evt;
        err                 <= 1'b0;
      end else begin
        write_fault_flag    <= write_fault_flag
                               | write_fault_evt;
        corrected_data_flag <= corrected_data_flag
                               | corrected_evt;
        err                 <= err | end_err;
      end
      if (cmd_wr) errreg <= 8'h00;
      else if (end_err) begin
        // Invalid opcode or timeout reports abort
        errreg <= op_error ? (op_err_bits & ERR_MASK) : ERR_ABORT;
      end
    end
  end

  // Completion and data phase raise the request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) intr_pend <= 1'b0;
    else if (soft_reset) intr_pend <= 1'b0;
    else if (end_ok | end_err | drq_set) intr_pend <= 1'b1;
    else if (stat_rd) intr_pend <= 1'b0;
  end

  // Interrupt gated by the active-low enable
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tf.intrq   <= 1'b0;
      config_int <= 1'b0;
    end else begin
      tf.intrq   <= intr_pend & ~nien;
      config_int <= intr_pend & ~nien;
    end
  end

  // Falls with drq on the same edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) tf.dmarq <= 1'b0;
    else tf.dmarq <= is_dma & (state == S_XFER) & ~soft_reset
                     & ~end_ok & ~end_err;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) data_phase <= 1'b0;
    else data_phase <= drq_set | (drq & ~end_ok & ~end_err & ~soft_reset);
  end

  ///////////////////////////////////////////////////////////////////////////
  // Command block registers, locked while busy
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      task_feature <= 8'h00;
      task_count   <= 8'h00;
      task_addr    <= 24'h00_0000;
      task_drvhead <= 8'h00;
    end else if (end_err & op_error & fail_addr_valid) begin
      task_addr         <= fail_addr[23:0];
      task_drvhead[3:0] <= fail_addr[27:24];
    end else if (take & tf.we & ~busy) begin
      case (tf.addr)
        TF_ERROR:   task_feature     <= tf.wdata;
        TF_SECCNT:  task_count       <= tf.wdata;
        TF_SECNUM:  task_addr[7:0]   <= tf.wdata;
        TF_CYLLO:   task_addr[15:8]  <= tf.wdata;
        TF_CYLHI:   task_addr[23:16] <= tf.wdata;
        TF_DRVHEAD: task_drvhead     <= tf.wdata;
        default:    task_feature     <= task_feature;
      endcase
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle after the request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tf.ack   <= 1'b0;
      tf.rdata <= 8'h00;
    end else begin
      tf.ack <= take;
      if (take & ~tf.we) begin
        case (tf.addr)
          TF_ERROR:   tf.rdata <= errreg;
          TF_SECCNT:  tf.rdata <= task_count;
          TF_SECNUM:  tf.rdata <= task_addr[7:0];
          TF_CYLLO:   tf.rdata <= task_addr[15:8];
          TF_CYLHI:   tf.rdata <= task_addr[23:16];
          TF_DRVHEAD: tf.rdata <= task_drvhead;
          // Same bits for both; only offset 7 clears
          TF_STATUS, TF_ALTSTAT: tf.rdata <= status;
          TF_DRVADDR: tf.rdata <= {1'b0,
                                   ~(is_out & (state == S_PREP
                                     || state == S_XFER)),
                                   ~task_drvhead[3:0],
                                   ds1_n, ds0_n};
          default:    tf.rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : ata_device

//--- rtl/ata_host.sv
// Purpose: Host adapter end: Avalon-MM slave driving the task-file link
// Assumes: Software writes ACCESS, then reads RESULT
// Notes:   Command writes wait on a shadow-status poll until not busy
`timescale 1ns/1ps
module ata_host (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  ata_if.host              tf
);
  import ata_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_POLL = 4'b0010,
    H_ACC  = 4'b0100,
    H_RESP = 4'b1000
  } ata_host_state_t;

  ata_host_state_t state;
  logic [3:0]      acc_addr;
  logic [7:0]      acc_data;
  logic            acc_we;
  logic [7:0]      result;
  logic [3:0]      new_addr;

  assign new_addr = avs_writedata[AC_ADDR_LO +: 4];

  ///////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state           <= H_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      acc_addr        <= 4'h0;
      acc_data        <= 8'h00;
      acc_we          <= 1'b0;
      result          <= 8'h00;
      tf.req          <= 1'b0;
      tf.we           <= 1'b0;
      tf.addr         <= 4'h0;
      tf.wdata        <= 8'h00;
    end else begin
      case (state)
        H_IDLE: begin
          if (avs_write && avs_address == HR_ACCESS) begin
            acc_addr <= new_addr;
            acc_we   <= avs_writedata[AC_WE];
            // Unused control bits go out as zero
            acc_data <= (new_addr == TF_ALTSTAT)
                        ? (avs_writedata[7:0] & DC_USED_MASK)
                        : avs_writedata[7:0];
            tf.req   <= 1'b1;
            if (avs_writedata[AC_WE] && new_addr == TF_STATUS) begin
              // Poll for not busy before any command
              tf.we   <= 1'b0;
              tf.addr <= TF_ALTSTAT;
              state   <= H_POLL;
            end else begin
              tf.we    <= avs_writedata[AC_WE];
              tf.addr  <= new_addr;
              tf.wdata <= avs_writedata[7:0] & ((new_addr == TF_ALTSTAT)
                          ? DC_USED_MASK : 8'hFF);
              state    <= H_ACC;
            end
          end else if (avs_read | avs_write) begin
            case (avs_address)
              HR_RESULT: avs_readdata <= {24'h00_0000, result};
              HR_LINK:   avs_readdata <= {30'h0000_0000, tf.dmarq, tf.intrq};
              default:   avs_readdata <= 32'h0000_0000;
            endcase
            avs_waitrequest <= 1'b0;
            state           <= H_RESP;
          end
        end
        H_POLL: begin
          if (tf.ack && !tf.rdata[ST_BUSY]) begin
            // Parameters were loaded by earlier accesses
            tf.we    <= 1'b1;
            tf.addr  <= TF_STATUS;
            tf.wdata <= acc_data;
            state    <= H_ACC;
          end
        end
        H_ACC: begin
          if (tf.ack) begin
            tf.req <= 1'b0;
            // Other status bits mean nothing while busy
            if (!acc_we && (acc_addr == TF_STATUS ||
                            acc_addr == TF_ALTSTAT) && tf.rdata[ST_BUSY])
              result <= BUSY_ONLY;
            else if (!acc_we)
              result <= tf.rdata;
            avs_waitrequest <= 1'b0;
            state           <= H_RESP;
          end
        end
        H_RESP: begin
          avs_waitrequest <= 1'b1;
          state           <= H_IDLE;
        end
        default: begin
          avs_waitrequest <= 1'b1;
          tf.req          <= 1'b0;
          state           <= H_IDLE;
        end
      endcase
    end
  end
endmodule : ata_host

//--- test/ata_link_checker.sv
// Purpose: Link checks between host adapter and card
// Assumes: One mclk domain, reset async high
// Notes:   Helpers mirror drive control writes
`timescale 1ns/1ps
module ata_link_checker (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       req,
  input wire logic       we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       intrq,
  input wire logic       dmarq
);
  import ata_pkg::*;
  logic nien_q;
  logic srst_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // Taken on the answer edge, so device copies lead by one cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nien_q <= 1'b0;
      srst_q <= 1'b0;
    end else if (ack && we && addr == TF_ALTSTAT) begin
      nien_q <= wdata[DC_NIEN];
      srst_q <= wdata[DC_SRST];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_stat_rd;
    ack && !we && (addr == TF_STATUS || addr == TF_ALTSTAT);
  endsequence
  a_ack_one_pulse: assert property (s_take |=> ack ##1 !ack)
    else $error("link answer not a single pulse");
  a_req_held: assert property (s_take |=> req)
    else $error("request dropped before answer");
  a_index_zero: assert property (s_stat_rd |-> !rdata[1])
    else $error("index bit not zero");
  a_dmarq_gated: assert property (
    s_stat_rd ##0 dmarq |-> rdata[ST_BUSY] || rdata[ST_DRQ])
    else $error("dma request without busy or data request");
  a_status_clears: assert property (
    ack && !we && addr == TF_STATUS && !rdata[ST_BUSY] |-> ##3 !intrq)
    else $error("status read left interrupt pending");
  a_shadow_keeps: assert property (
    ack && !we && addr == TF_ALTSTAT && intrq |=> intrq)
    else $error("shadow read cleared interrupt");
  a_nien_masks: assert property (
    nien_q && $past(nien_q, 2) |-> !intrq)
    else $error("interrupt seen while disabled");
  a_srst_busy: assert property (
    s_stat_rd ##0 (srst_q && $past(srst_q)) |-> rdata[ST_BUSY])
    else $error("not busy during soft reset");
endmodule : ata_link_checker

//--- test/testbench.sv
// Purpose: Self-checking bench for both link ends
// Assumes: Software side over Avalon-MM, back end driven here
// Notes:   Short data request limits keep aborts quick
`timescale 1ns/1ps
module testbench;
  import ata_pkg::*;
  localparam logic [7:0] BAD_OPS [11] = '{8'h00, 8'h22, 8'h23, 8'hB9,
    8'hE7, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6};
  logic        mclk;
  logic        reset;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        media_ready;
  logic [3:0]  evt_bits; // Fault, corrected, done, error
  logic        buf_ready;
  logic [7:0]  op_err_bits;
  logic        fail_addr_valid;
  logic [27:0] fail_addr;
  logic        cmd_start;
  logic        data_phase;
  logic        soft_reset;
  logic        config_int;
  logic [7:0]  opcode;
  logic [7:0]  count;
  logic [7:0]  feature;
  logic [31:0] rd;
  int          miscompares;
  int          checks_done;
  int          cycles;
  int          starts;
  ata_if tf_link ();
  ata_device #(.DRQ_OUT_LIM(50), .DRQ_IN_LIM(80)) ata_device_inst (
    .mclk(mclk), .reset(reset), .tf(tf_link.device),
    .media_ready(media_ready), .write_fault_evt(evt_bits[3]),
    .corrected_evt(evt_bits[2]), .buf_ready(buf_ready),
    .op_done(evt_bits[1]),
    .op_error(evt_bits[0]), .op_err_bits(op_err_bits),
    .fail_addr_valid(fail_addr_valid), .fail_addr(fail_addr),
    .cmd_start(cmd_start), .cmd_opcode(opcode), .data_phase(data_phase),
    .soft_reset(soft_reset), .config_int(config_int), .task_count(count),
    .task_feature(feature), .task_drvhead(), .task_addr());
  ata_host ata_host_inst (
    .mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tf(tf_link.host));
  ata_link_checker ata_link_checker_inst (
    .mclk(mclk), .reset(reset), .req(tf_link.req), .we(tf_link.we),
    .addr(tf_link.addr), .wdata(tf_link.wdata), .ack(tf_link.ack),
    .rdata(tf_link.rdata), .intrq(tf_link.intrq), .dmarq(tf_link.dmarq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cmd_start === 1'b1)
      starts++;
    // Whole run needs under a thousand cycles
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask : av
  task automatic tf_wr(input logic [3:0] i, input logic [7:0] d);
    av(HR_ACCESS, 1'b1, {19'h0, 1'b1, i, d});
  endtask : tf_wr
  task automatic rck(input string what, input logic [3:0] i,
                     input logic [7:0] exp);
    av(HR_ACCESS, 1'b1, {19'h0, 1'b0, i, 8'h00});
    av(HR_RESULT, 1'b0, 32'h0);
    check(what, rd, {24'h0, exp});
  endtask : rck
  task automatic lck(input logic [1:0] exp);
    av(HR_LINK, 1'b0, 32'h0);
    check("link", rd, {30'h0, exp});
  endtask : lck
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic evt(input logic [3:0] m);
    evt_bits <= m;
    @(posedge mclk);
    evt_bits <= 4'h0;
    @(posedge mclk);
  endtask : evt
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ready();
    rck("not ready", TF_STATUS, 8'h00);
    media_ready <= 1'b1;
    cyc(2);
    rck("ready", TF_STATUS, 8'h50);
    av(2'h3, 1'b1, 32'hFFFF);
    av(2'h3, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    tf_wr(TF_DRVHEAD, 8'hA5);
    rck("drive address", TF_DRVADDR, 8'h6A);
    tf_wr(TF_SECCNT, 8'h3C);
    tf_wr(TF_ERROR, 8'hC3);
    check("count", count, 32'h3C);
    check("feature", feature, 32'hC3);
    $display("t_ready done");
  endtask : t_ready
  task automatic t_class1();
    int s;
    s = starts;
    tf_wr(TF_ALTSTAT, 8'hFA);
    tf_wr(TF_STATUS, 8'h90);
    rck("busy", TF_ALTSTAT, BUSY_ONLY);
    check("started", starts, s + 1);
    check("opcode", opcode, 32'h90);
    evt(4'h2);
    cyc(3);
    lck(2'h0);
    check("config int", config_int, 32'h0);
    tf_wr(TF_ALTSTAT, 8'h00);
    cyc(3);
    lck(2'h1);
    rck("shadow", TF_ALTSTAT, 8'h50);
    lck(2'h1);
    rck("status", TF_STATUS, 8'h50);
    cyc(3);
    lck(2'h0);
    $display("t_class1 done");
  endtask : t_class1
  task automatic t_unsup();
    int s;
    foreach (BAD_OPS[i]) begin
      s = starts;
      tf_wr(TF_STATUS, BAD_OPS[i]);
      cyc(4);
      rck("refused", TF_STATUS, 8'h51);
      rck("abort", TF_ERROR, ERR_ABORT);
      check("no start", starts, s);
    end
    $display("t_unsup done");
  endtask : t_unsup
  task automatic t_timeout();
    tf_wr(TF_STATUS, 8'hCA);
    cyc(60);
    rck("late", TF_STATUS, 8'h51);
    rck("late abort", TF_ERROR, ERR_ABORT);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_class3();
    buf_ready <= 1'b1;
    tf_wr(TF_STATUS, 8'hC8);
    cyc(4);
    lck(2'h3);
    evt(4'h4);
    rck("corrected", TF_STATUS, 8'h5C);
    evt(4'h2);
    cyc(3);
    lck(2'h1);
    $display("t_class3 done");
  endtask : t_class3
  task automatic t_fault();
    buf_ready <= 1'b0;
    tf_wr(TF_STATUS, 8'h30);
    cyc(10);
    buf_ready <= 1'b1;
    cyc(2);
    rck("out drq", TF_STATUS, 8'h58);
    rck("gate", TF_DRVADDR, 8'h2A);
    check("phase", data_phase, 32'h1);
    fail_addr <= 28'h0123456;
    fail_addr_valid <= 1'b1;
    op_err_bits <= 8'h10;
    evt(4'h9);
    fail_addr_valid <= 1'b0;
    buf_ready <= 1'b0;
    rck("fault", TF_STATUS, 8'h71);
    rck("cause", TF_ERROR, 8'h10);
    rck("sec", TF_SECNUM, 8'h56);
    rck("cyl lo", TF_CYLLO, 8'h34);
    rck("cyl hi", TF_CYLHI, 8'h12);
    $display("t_fault done");
  endtask : t_fault
  task automatic t_srst();
    tf_wr(TF_STATUS, 8'h90);
    tf_wr(TF_SECCNT, 8'h11);
    tf_wr(TF_ALTSTAT, 8'hFC);
    rck("held", TF_STATUS, BUSY_ONLY);
    check("srst on", soft_reset, 32'h1);
    tf_wr(TF_ALTSTAT, 8'hF9);
    cyc(2);
    check("srst off", soft_reset, 32'h0);
    rck("after", TF_STATUS, 8'h50);
    rck("locked", TF_SECCNT, 8'h3C);
    lck(2'h0);
    $display("t_srst done");
  endtask : t_srst
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {media_ready, evt_bits, buf_ready, op_err_bits} = '0;
    {fail_addr_valid, fail_addr} = '0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_ready();
    t_class1();
    t_unsup();
    t_timeout();
    t_class3();
    t_fault();
    t_srst();
    results();
  end
endmodule : testbench
